// [dv/arbiter_assertions.sv]
`timescale 1ns/1ps
module arbiter_assertions (
  // Clock, reset and bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side and wake.
  input wire logic [3:0]  core_level,
  input wire logic        core_ack,
  input wire logic        irq_valid,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0]  irq_level,
  input wire logic        irq_is_exception,
  input wire logic        power_down,
  input wire logic [1:0]  ext_level_mode,
  input wire logic        wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The bus never waits, so a missing or stray ready is a real fault.
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_only: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h1c
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not quiet");
  // Offers toward the core.
  a_level_nonzero: assert property (irq_valid |->
    irq_level != 4'h0) else $error("offer at level zero");
  a_exc_level: assert property (irq_valid && irq_is_exception |->
    irq_level == 4'hf) else $error("exception level wrong");
  a_above_core: assert property (irq_valid && !irq_is_exception
    |-> irq_level > $past(core_level)) else $error("offer not above core");
  a_event_range: assert property (irq_valid && !irq_is_exception
    |-> irq_vector[1:0] == 2'b00 && irq_vector >= 16'h0080 &&
    irq_vector < 16'h0120) else $error("event vector out of range");
  a_event_level: assert property (irq_valid && !irq_is_exception &&
    irq_vector < 16'h0100 |-> irq_level[3]) else $error("event level low");
  a_ack_drop: assert property (irq_valid && core_ack |=>
    !irq_valid) else $error("offer kept after ack");
  a_wake_cause: assert property (wake |-> $past(power_down) &&
    $past(ext_level_mode) != 2'b00) else $error("wake without cause");
  // Main scenarios.
  c_exception: cover property (irq_valid && irq_is_exception && core_ack);
  c_event: cover property (irq_valid && !irq_is_exception && core_ack);
  c_wake: cover property (wake);
endmodule // arbiter_assertions

// [dv/core_model.sv]
`timescale 1ns/1ps
module core_model (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Offer and the answer delay chosen by the bench.
  input wire logic       irq_valid,
  input wire logic [1:0] ack_delay,
  output logic           core_ack
);
  logic [1:0] wait_count;
  // The ack is a one-cycle pulse and never repeats at once, so each pulse
  // accepts exactly one offer; a dropped offer simply ignores it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack   <= 1'b0;
      wait_count <= 2'b00;
    end else begin
      core_ack <= 1'b0;
      if (irq_valid && !core_ack) begin
        if (wait_count >= ack_delay) begin
          core_ack   <= 1'b1;
          wait_count <= 2'b00;
        end else begin
          wait_count <= wait_count + 2'b01;
        end
      end
    end
  end
endmodule // core_model

// [dv/tb_event_interrupt_priority_arbiter.sv]
`timescale 1ns/1ps
module tb_event_interrupt_priority_arbiter;
  localparam logic [15:0] BOOT = 16'h0200;
  // Bench signals.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [8:0]  event_flag = 9'h000;
  logic [6:0]  swint_flag = 7'h00;
  logic [4:0]  hwtrap_pulse = 5'h00;
  logic        swtrap_pulse = 1'b0;
  logic [3:0]  swtrap_number = 4'h0;
  logic        force_boot = 1'b0;
  logic [7:0]  flash_status = 8'h00;
  logic        power_down = 1'b0;
  logic [1:0]  ext_level_mode = 2'b00;
  logic [3:0]  core_level = 4'h0;
  logic [1:0]  ack_delay = 2'b00;
  logic        core_ack;
  logic        irq_valid;
  logic [15:0] irq_vector;
  logic [3:0]  irq_level;
  logic        irq_is_exception;
  logic        wake;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2 pclk = ~pclk;

  // Software interrupts share the event arbitration path.
  event_interrupt_priority_arbiter #(.BOOT_VECTOR(BOOT)) uut (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .event_flag, .swint_flag, .hwtrap_pulse, .swtrap_pulse,
    .swtrap_number, .force_boot, .flash_status, .power_down, .ext_level_mode,
    .core_level, .core_ack, .irq_valid, .irq_vector, .irq_level,
    .irq_is_exception, .wake);
  core_model core (.pclk, .presetn, .irq_valid, .ack_delay, .core_ack);

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for an offer, compares it, then waits until the core takes it.
  // The first edge lets an offer that was just acknowledged retire.
  task automatic expect_offer(input string what, input logic [15:0] vec,
                              input logic [3:0] lvl, input logic exc);
    @(posedge pclk);
    while (irq_valid !== 1'b1) begin
      @(posedge pclk);
    end
    check(what, {exc, lvl, vec}, {irq_is_exception, irq_level, irq_vector});
    while (!(irq_valid === 1'b1 && core_ack === 1'b1)) begin
      @(posedge pclk);
    end
  endtask

  task automatic do_reset(input logic fb, input logic [7:0] fs,
                          input logic [15:0] vec, input int hold);
    @(posedge pclk);
    presetn      <= 1'b0;
    force_boot   <= fb;
    flash_status <= fs;
    repeat (hold) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check("reset offer at edge two", 1'b1, irq_valid);
    expect_offer("reset offer", vec, 4'hf, 1'b1);
    repeat (4) @(posedge pclk);
    check("reset offer cleared", 1'b0, irq_valid);
  endtask

  task automatic t_regs();
    logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] msk [7] = '{32'h9f, 32'h0f, 32'h77, 32'h77, 32'h07,
                             32'h77, 32'h77};
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      check("register reset value", 32'h0, rd);
      apb(1'b1, ofs[i], 32'hffffffff);
      apb(1'b0, ofs[i], 32'h0);
      check("register masked value", msk[i], rd);
      apb(1'b1, ofs[i], 32'h0);
    end
    apb(1'b1, 8'h20, 32'hffffffff);
    check("unmapped write error", 1'b1, err);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped read error", 1'b1, err);
    check("unmapped read data", 32'h0, rd);
    apb(1'b1, 8'h1c, 32'hffffffff);
    check("status write error", 1'b0, err);
    $display("test registers done");
  endtask

  // Each source alone, with fields 1..7 then 1 and 2 again, prompt and slow core.
  task automatic t_events();
    logic [7:0] ofs;
    logic [2:0] fld;
    apb(1'b1, 8'h00, 32'h9f);
    apb(1'b1, 8'h04, 32'h0f);
    for (int i = 0; i < 9; i++) begin
      fld = 3'(i % 7 + 1);
      ofs = (i < 5) ? 8'(8 + 4 * (i / 2)) : 8'(8 + 4 * ((i + 1) / 2));
      ack_delay <= 2'(i);
      apb(1'b1, ofs, 32'(fld) << (((i < 5) == (i % 2 == 0)) ? 0 : 4));
      event_flag[i] <= 1'b1;
      expect_offer("event offer", (i < 5) ? 16'(16'h80 + 4 * i) :
                   16'(16'ha0 + 4 * (i - 5)), {1'b1, fld}, 1'b0);
      event_flag[i] <= 1'b0;
      apb(1'b1, ofs, 32'h0);
    end
    $display("test events done");
  endtask

  task automatic t_rank();
    apb(1'b1, 8'h0c, 32'h44);
    event_flag[3:2] <= 2'b11;
    expect_offer("tie first", 16'h0088, 4'hc, 1'b0);
    event_flag[2] <= 1'b0;
    expect_offer("tie second", 16'h008c, 4'hc, 1'b0);
    core_level <= 4'hc;
    repeat (8) @(posedge pclk);
    check("level at core level held", 1'b0, irq_valid);
    core_level <= 4'hb;
    expect_offer("level above core", 16'h008c, 4'hc, 1'b0);
    core_level <= 4'h0;
    apb(1'b1, 8'h00, 32'h1f);
    repeat (6) @(posedge pclk);
    check("global disable", 1'b0, irq_valid);
    apb(1'b1, 8'h0c, 32'h04);
    apb(1'b1, 8'h00, 32'h9f);
    repeat (6) @(posedge pclk);
    check("zero field held", 1'b0, irq_valid);
    event_flag <= 9'h000;
    apb(1'b1, 8'h0c, 32'h0);
    swint_flag[2] <= 1'b1;
    expect_offer("swint offer", 16'h0108, 4'h3, 1'b0);
    swint_flag <= 7'h00;
    $display("test ranking done");
  endtask

  // Traps must pass even with the core at its top level.
  task automatic t_traps();
    core_level <= 4'hf;
    for (int n = 0; n < 21; n++) begin
      if (n < 5) begin
        hwtrap_pulse[n] <= 1'b1;
      end else begin
        swtrap_pulse  <= 1'b1;
        swtrap_number <= 4'(n - 5);
      end
      @(posedge pclk);
      hwtrap_pulse <= 5'h00;
      swtrap_pulse <= 1'b0;
      expect_offer("trap offer", 16'(n < 5 ? 4 + 4 * n : 64 + 4 * (n - 5)),
                   4'hf, 1'b1);
    end
    core_level <= 4'h0;
    $display("test traps done");
  endtask

  task automatic t_wake();
    apb(1'b1, 8'h00, 32'h81);
    power_down     <= 1'b1;
    ext_level_mode <= 2'b01;
    event_flag[0]  <= 1'b1;
    repeat (3) @(posedge pclk);
    check("wake in level mode", 1'b1, wake);
    ext_level_mode <= 2'b10;
    repeat (3) @(posedge pclk);
    check("no wake in edge mode", 1'b0, wake);
    power_down <= 1'b0;
    event_flag <= 9'h000;
    $display("test wake done");
  endtask

  // Cuts a hang short well above the few thousand cycles the run needs.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    do_reset(1'b0, 8'h00, 16'h0000, 20);
    do_reset(1'b0, 8'h80, BOOT, irq_arb_pkg::RESET_MIN_CYCLES);
    do_reset(1'b1, 8'h00, BOOT, irq_arb_pkg::RESET_MIN_CYCLES);
    $display("test reset done");
    t_regs();
    t_events();
    t_rank();
    t_traps();
    t_wake();
    summarize();
  end
endmodule // tb_event_interrupt_priority_arbiter

bind event_interrupt_priority_arbiter arbiter_assertions chk (.pclk,
  .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .core_level,
  .core_ack, .irq_valid, .irq_vector, .irq_level, .irq_is_exception,
  .power_down, .ext_level_mode, .wake);

// [rtl/cand_arbiter.sv]
`timescale 1ns/1ps
module cand_arbiter (
  // Candidate requests, index order equals arbitration ranking.
  input  wire logic [15:0]   cand_valid,
  input  wire logic [63:0]   cand_level,
  // Winner.
  output logic               win_valid,
  output logic [3:0]         win_index,
  output logic [3:0]         win_level
);

  // Strictly greater replaces, so the lower index keeps a tie.
  always_comb begin
    win_valid = 1'b0;
    win_index = 4'h0;
    win_level = 4'h0;
    for (int i = 0; i < irq_arb_pkg::NUM_CAND; i++) begin
      if (cand_valid[i] && cand_level[i*4 +: 4] != 4'h0 &&
          (!win_valid || cand_level[i*4 +: 4] > win_level)) begin
        win_valid = 1'b1;
        win_index = 4'(i);
        win_level = cand_level[i*4 +: 4];
      end
    end
  end

endmodule // cand_arbiter

// [rtl/event_interrupt_priority_arbiter.sv]
`timescale 1ns/1ps
module event_interrupt_priority_arbiter #(
  parameter logic [15:0] BOOT_VECTOR = 16'h0000
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral event flags, in ranking order from external 0.
  input  wire logic [8:0]  event_flag,
  // Software interrupt flags, already gated by their own enables.
  input  wire logic [6:0]  swint_flag,
  // Exception and trap requests, one-cycle pulses.
  input  wire logic [4:0]  hwtrap_pulse,
  input  wire logic        swtrap_pulse,
  input  wire logic [3:0]  swtrap_number,
  // Boot selection, sampled once after reset release.
  input  wire logic        force_boot,
  input  wire logic [7:0]  flash_status,
  // Power-down state and external input trigger modes.
  input  wire logic        power_down,
  input  wire logic [1:0]  ext_level_mode,
  // Core side.
  input  wire logic [3:0]  core_level,
  input  wire logic        core_ack,
  output logic             irq_valid,
  output logic [15:0]      irq_vector,
  output logic [3:0]       irq_level,
  output logic             irq_is_exception,
  output logic             wake
);

  logic [7:0]  irq_enable_low_reg;
  logic [7:0]  irq_enable_high_reg;
  logic [7:0]  ext0_timer0_priority_reg;
  logic [7:0]  ext1_timer1_priority_reg;
  logic [7:0]  timer2_priority_reg;
  logic [7:0]  uart0_priority_reg;
  logic [7:0]  uart1_priority_reg;
  logic        reset_pending;
  logic        boot_sampled;
  logic        boot_select;
  logic [4:0]  hwtrap_pending;
  logic [15:0] swtrap_pending;
  logic [8:0]  event_gated;
  logic [15:0] cand_valid;
  logic [63:0] cand_level;
  logic        win_valid;
  logic [3:0]  win_index;
  logic [3:0]  win_level;
  logic        sel_valid;
  irq_arb_pkg::kind_type sel_kind;
  logic [3:0]  sel_index;
  logic [3:0]  sel_level;
  logic [15:0] sel_vector;
  logic [15:0] reset_target;
  logic        global_irq_enable;
  logic        ext0_enable;
  logic        ext1_enable;
  logic        taken_ack;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic [31:0] next_prdata;

  // Enable fields pulled out of the low enable register.
  assign global_irq_enable =
    irq_enable_low_reg[irq_arb_pkg::EN_GLOBAL_POS];
  assign ext0_enable = irq_enable_low_reg[irq_arb_pkg::EN_EXT0_POS];
  assign ext1_enable = irq_enable_low_reg[irq_arb_pkg::EN_EXT1_POS];

  // Each event needs the global enable and its own enable bit.
  always_comb begin
    event_gated[0] = event_flag[0] && ext0_enable;
    event_gated[1] = event_flag[1] &&
      irq_enable_low_reg[irq_arb_pkg::EN_TIMER0_POS];
    event_gated[2] = event_flag[2] && ext1_enable;
    event_gated[3] = event_flag[3] &&
      irq_enable_low_reg[irq_arb_pkg::EN_TIMER1_POS];
    event_gated[4] = event_flag[4] &&
      irq_enable_low_reg[irq_arb_pkg::EN_TIMER2_POS];
    event_gated[5] = event_flag[5] &&
      irq_enable_high_reg[irq_arb_pkg::EN_U0RX_POS];
    event_gated[6] = event_flag[6] &&
      irq_enable_high_reg[irq_arb_pkg::EN_U0TX_POS];
    event_gated[7] = event_flag[7] &&
      irq_enable_high_reg[irq_arb_pkg::EN_U1RX_POS];
    event_gated[8] = event_flag[8] &&
      irq_enable_high_reg[irq_arb_pkg::EN_U1TX_POS];
    event_gated = event_gated & {9{global_irq_enable}};
  end

  // Candidate list in ranking order: events first, then the software
  // interrupts with their fixed levels one to seven.
  always_comb begin
    cand_valid = {swint_flag, event_gated};
    cand_level[3:0]   = irq_arb_pkg::eff_priority(
      ext0_timer0_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_LO_POS +: 3]);
    cand_level[7:4]   = irq_arb_pkg::eff_priority(
      ext0_timer0_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_HI_POS +: 3]);
    cand_level[11:8]  = irq_arb_pkg::eff_priority(
      ext1_timer1_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_LO_POS +: 3]);
    cand_level[15:12] = irq_arb_pkg::eff_priority(
      ext1_timer1_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_HI_POS +: 3]);
    cand_level[19:16] = irq_arb_pkg::eff_priority(
      timer2_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_LO_POS +: 3]);
    cand_level[23:20] = irq_arb_pkg::eff_priority(
      uart0_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_LO_POS +: 3]);
    cand_level[27:24] = irq_arb_pkg::eff_priority(
      uart0_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_HI_POS +: 3]);
    cand_level[31:28] = irq_arb_pkg::eff_priority(
      uart1_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_LO_POS +: 3]);
    cand_level[35:32] = irq_arb_pkg::eff_priority(
      uart1_priority_reg[irq_arb_pkg::UART0_RX_PRIORITY_HI_POS +: 3]);
    for (int s = 0; s < irq_arb_pkg::NUM_SWINT; s++) begin
      cand_level[36 + s*4 +: 4] = 4'(s + 1);
    end
  end

  // Level and ranking arbitration among maskable candidates.
  cand_arbiter u_cand_arbiter (
    .cand_valid (cand_valid),
    .cand_level (cand_level),
    .win_valid  (win_valid),
    .win_index  (win_index),
    .win_level  (win_level)
  );

  // Exceptions outrank everything: reset first, then hardware traps in
  // slot order, then software traps; events only above the core level.
  always_comb begin
    sel_valid = 1'b0;
    sel_kind  = irq_arb_pkg::KIND_RESET;
    sel_index = 4'h0;
    sel_level = irq_arb_pkg::EXC_LEVEL;
    if (reset_pending && boot_sampled) begin
      sel_valid = 1'b1;
    end else if (hwtrap_pending != 5'h00) begin
      sel_valid = 1'b1;
      sel_kind  = irq_arb_pkg::KIND_HWTRAP;
      for (int t = irq_arb_pkg::NUM_HWTRAP - 1; t >= 0; t--) begin
        if (hwtrap_pending[t]) begin
          sel_index = 4'(t);
        end
      end
    end else if (swtrap_pending != 16'h0000) begin
      sel_valid = 1'b1;
      sel_kind  = irq_arb_pkg::KIND_SWTRAP;
      for (int t = 15; t >= 0; t--) begin
        if (swtrap_pending[t]) begin
          sel_index = 4'(t);
        end
      end
    end else if (win_valid && win_level > core_level) begin
      sel_valid = 1'b1;
      sel_level = win_level;
      if (win_index < 4'(irq_arb_pkg::NUM_EVENTS)) begin
        sel_kind  = irq_arb_pkg::KIND_EVENT;
        sel_index = win_index;
      end else begin
        sel_kind  = irq_arb_pkg::KIND_SWINT;
        sel_index = win_index - 4'(irq_arb_pkg::NUM_EVENTS);
      end
    end
  end

  // The reset target is either page-zero word 0000 or the boot vector.
  assign reset_target = boot_select ? BOOT_VECTOR
                                    : irq_arb_pkg::VEC_RESET;

  // Slot address lookup; every vector is a sixteen-bit value, with the software interrupt slots from 0100.
  vector_map u_vector_map (
    .kind         (sel_kind),
    .index        (sel_index),
    .reset_target (reset_target),
    .vector       (sel_vector)
  );

  // Drive the core from flops; the offer is dropped for a cycle after an
  // acknowledge so that a cleared source cannot be taken twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_valid        <= 1'b0;
      irq_vector       <= 16'h0000;
      irq_level        <= 4'h0;
      irq_is_exception <= 1'b0;
    end else begin
      irq_valid        <= sel_valid && !taken_ack;
      irq_vector       <= sel_vector;
      irq_level        <= sel_level;
      irq_is_exception <= sel_kind == irq_arb_pkg::KIND_RESET ||
                          sel_kind == irq_arb_pkg::KIND_HWTRAP ||
                          sel_kind == irq_arb_pkg::KIND_SWTRAP;
    end
  end

  assign taken_ack = core_ack && irq_valid;

  // Reset exception is pending from reset and dropped when the core
  // takes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pending <= 1'b1;
    end else if (taken_ack && irq_vector == reset_target &&
                 irq_is_exception && reset_pending) begin
      reset_pending <= 1'b0;
    end
  end

  // Boot selection is caught one clock after release, never under reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_sampled <= 1'b0;
      boot_select  <= 1'b0;
    end else if (!boot_sampled) begin
      boot_sampled <= 1'b1;
      boot_select  <= force_boot || flash_status != 8'h00;
    end
  end

  // Trap pulses are held until the core takes them; a new pulse in the
  // acknowledge cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hwtrap_pending <= 5'h00;
      swtrap_pending <= 16'h0000;
    end else begin
      hwtrap_pending <= (hwtrap_pending &
        ~((taken_ack && !reset_pending &&
           irq_vector < irq_arb_pkg::VEC_SWTRAP)
          ? 5'(5'h01 << sel_index) : 5'h00)) | hwtrap_pulse;
      swtrap_pending <= (swtrap_pending &
        ~((taken_ack && hwtrap_pending == 5'h00 && !reset_pending &&
           sel_kind == irq_arb_pkg::KIND_SWTRAP)
          ? 16'(16'h0001 << sel_index) : 16'h0000)) |
        (swtrap_pulse ? 16'(16'h0001 << swtrap_number) : 16'h0000);
    end
  end

  // Wake only for an enabled, level-sensitive external input; any other
  // exit from power-down is left to reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= power_down && global_irq_enable &&
              ((event_flag[0] && ext0_enable && ext_level_mode[0]) ||
               (event_flag[2] && ext1_enable &&
                ext_level_mode[1]));
    end
  end

  // APB decode; every access completes with one wait-free access phase.
  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;
  always_comb begin
    addr_ok = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      irq_arb_pkg::OFS_ENABLE_LOW:  next_prdata[7:0] = irq_enable_low_reg;
      irq_arb_pkg::OFS_ENABLE_HIGH: next_prdata[7:0] = irq_enable_high_reg;
      irq_arb_pkg::OFS_UART0_RX_PRIORITY_EXT0:
        next_prdata[7:0] = ext0_timer0_priority_reg;
      irq_arb_pkg::OFS_UART0_RX_PRIORITY_EXT1:
        next_prdata[7:0] = ext1_timer1_priority_reg;
      irq_arb_pkg::OFS_UART0_RX_PRIORITY_TIMER2: next_prdata[7:0] = timer2_priority_reg;
      irq_arb_pkg::OFS_UART0_RX_PRIORITY_UART0:  next_prdata[7:0] = uart0_priority_reg;
      irq_arb_pkg::OFS_UART0_RX_PRIORITY_UART1:  next_prdata[7:0] = uart1_priority_reg;
      irq_arb_pkg::OFS_STATUS:
        next_prdata = {reset_pending, boot_select, 6'h00, win_level,
                       win_index, win_valid, 7'h00,
                       event_gated[7:0]};
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer registered in the setup cycle so pready is a flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !addr_ok;
      prdata  <= (rd_setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Writable registers; only the implemented enable and priority bits are kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_low_reg       <= irq_arb_pkg::ENABLE_RESET;
      irq_enable_high_reg      <= irq_arb_pkg::ENABLE_RESET;
      ext0_timer0_priority_reg <= irq_arb_pkg::UART0_RX_PRIORITY_RESET;
      ext1_timer1_priority_reg <= irq_arb_pkg::UART0_RX_PRIORITY_RESET;
      timer2_priority_reg      <= irq_arb_pkg::UART0_RX_PRIORITY_RESET;
      uart0_priority_reg       <= irq_arb_pkg::UART0_RX_PRIORITY_RESET;
      uart1_priority_reg       <= irq_arb_pkg::UART0_RX_PRIORITY_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        irq_arb_pkg::OFS_ENABLE_LOW:
          irq_enable_low_reg <= pwdata[7:0] & 8'h9f;
        irq_arb_pkg::OFS_ENABLE_HIGH:
          irq_enable_high_reg <= pwdata[7:0] & 8'h0f;
        irq_arb_pkg::OFS_UART0_RX_PRIORITY_EXT0:
          ext0_timer0_priority_reg <= pwdata[7:0] & 8'h77;
        irq_arb_pkg::OFS_UART0_RX_PRIORITY_EXT1:
          ext1_timer1_priority_reg <= pwdata[7:0] & 8'h77;
        irq_arb_pkg::OFS_UART0_RX_PRIORITY_TIMER2:
          timer2_priority_reg <= pwdata[7:0] & 8'h07;
        irq_arb_pkg::OFS_UART0_RX_PRIORITY_UART0:
          uart0_priority_reg <= pwdata[7:0] & 8'h77;
        irq_arb_pkg::OFS_UART0_RX_PRIORITY_UART1:
          uart1_priority_reg <= pwdata[7:0] & 8'h77;
        default: ;
      endcase
    end
  end

endmodule // event_interrupt_priority_arbiter

// [rtl/irq_arb_pkg.sv]
package irq_arb_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_ENABLE_LOW  = 8'h00;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'h04;
  localparam logic [7:0] OFS_UART0_RX_PRIORITY_EXT0   = 8'h08;
  localparam logic [7:0] OFS_UART0_RX_PRIORITY_EXT1   = 8'h0c;
  localparam logic [7:0] OFS_UART0_RX_PRIORITY_TIMER2 = 8'h10;
  localparam logic [7:0] OFS_UART0_RX_PRIORITY_UART0  = 8'h14;
  localparam logic [7:0] OFS_UART0_RX_PRIORITY_UART1  = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1c;

  // Low enable register fields.
  localparam int EN_EXT0_POS   = 0;
  localparam int EN_TIMER0_POS = 1;
  localparam int EN_EXT1_POS   = 2;
  localparam int EN_TIMER1_POS = 3;
  localparam int EN_TIMER2_POS = 4;
  localparam int EN_GLOBAL_POS = 7;
  // High enable register fields, serial port sources.
  localparam int EN_U0RX_POS   = 0;
  localparam int EN_U0TX_POS   = 1;
  localparam int EN_U1RX_POS   = 2;
  localparam int EN_U1TX_POS   = 3;
  // Priority register fields: low source in bits 2..0, high in 6..4.
  localparam int UART0_RX_PRIORITY_LO_POS   = 0;
  localparam int UART0_RX_PRIORITY_HI_POS   = 4;

  // Reset values.
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] UART0_RX_PRIORITY_RESET   = 8'h00;

  // Source counts.
  localparam int NUM_EVENTS    = 9;
  localparam int NUM_SWINT     = 7;
  localparam int NUM_CAND      = NUM_EVENTS + NUM_SWINT;
  localparam int NUM_HWTRAP    = 5;

  // Vector bases; every slot is four bytes.
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_HWTRAP  = 16'h0004;
  localparam logic [15:0] VEC_SWTRAP  = 16'h0040;
  localparam logic [15:0] VEC_EVENT_A = 16'h0080;
  localparam logic [15:0] VEC_EVENT_B = 16'h00a0;
  localparam logic [15:0] VEC_SWINT   = 16'h0100;
  localparam logic [3:0]  EXC_LEVEL   = 4'hf;

  // Shortest reset pulse that the board must give, and its cycle count.
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int RESET_MIN_NS      = 10000;
  localparam int RESET_MIN_CYCLES  =
    (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Kind of request offered to the core.
  typedef enum logic [2:0] {
    KIND_RESET  = 3'b000,
    KIND_HWTRAP = 3'b001,
    KIND_SWTRAP = 3'b010,
    KIND_EVENT  = 3'b011,
    KIND_SWINT  = 3'b100
  } kind_type;

  // A zero field disables; otherwise the implied top bit is set.
  function automatic logic [3:0] eff_priority(input logic [2:0] field);
    eff_priority = (field == 3'h0) ? 4'h0 : {1'b1, field};
  endfunction

endpackage

// [rtl/vector_map.sv]
`timescale 1ns/1ps
module vector_map (
  // Selected source.
  input  irq_arb_pkg::kind_type kind,
  input  wire logic [3:0]       index,
  input  wire logic [15:0]      reset_target,
  // Vector address of the slot.
  output logic [15:0]           vector
);

  // Each slot is four bytes, so the index lands on bit two.
  always_comb begin
    unique case (kind)
      irq_arb_pkg::KIND_RESET:  vector = reset_target;
      irq_arb_pkg::KIND_HWTRAP:
        vector = irq_arb_pkg::VEC_HWTRAP + {10'h000, index, 2'b00};
      irq_arb_pkg::KIND_SWTRAP:
        vector = irq_arb_pkg::VEC_SWTRAP + {10'h000, index, 2'b00};
      irq_arb_pkg::KIND_EVENT: begin
        if (index < 4'h5) begin
          vector = irq_arb_pkg::VEC_EVENT_A + {10'h000, index, 2'b00};
        end else begin
          vector = irq_arb_pkg::VEC_EVENT_B +
                   {10'h000, index - 4'h5, 2'b00};
        end
      end
      irq_arb_pkg::KIND_SWINT:
        vector = irq_arb_pkg::VEC_SWINT + {10'h000, index, 2'b00};
      default: vector = irq_arb_pkg::VEC_RESET;
    endcase
  end

endmodule // vector_map
